// ===== logic/ocfc_channel.sv
// Channel four clock output control: AXI4-Lite registers, source mux, divider and leg drive
//
// The AXI4-Lite interface to the registers is this design's own decision.
module ocfc_channel #(
  parameter int ADDR_W = 8,
  parameter int DIV_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Candidate clock sources, sampled as levels
  input wire logic first_synthesizer_clk,
  input wire logic second_synthesizer_clk,
  input wire logic primary_reference_clk,
  input wire logic secondary_reference_clk,
  // Output stage
  output logic out_pos,
  output logic out_pos_oe,
  output logic out_neg,
  output logic out_neg_oe,
  output ocfc_pkg::ocfc_fmt_t driver_format,
  output logic [4:0] tail_current_ma,
  output logic [1:0] hcsl_load_code,
  output logic divider_active
);
  import ocfc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] output_four_control_q; // Control register
  logic [7:0] output_four_divider_q; // Divider register
  logic aw_full_q; // Write address held
  logic w_full_q; // Write data held
  logic aw_full_d;
  logic w_full_d;
  logic [5:0] aw_idx_q; // Held write index
  logic aw_ok_q; // Held write address is mapped
  logic [7:0] w_byte_q; // Held low data byte
  logic w_lane_q; // Low byte lane enabled
  logic bvalid_d;
  logic rvalid_d;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write; // Both halves of a write present
  logic [5:0] ar_idx;
  ocfc_src_t channel_four_source_select; // Field views of the control register
  ocfc_fmt_t fmt;
  logic [1:0] channel_four_drive_mode_a;
  logic [1:0] channel_four_drive_mode_b;
  logic synth_src; // Source is one of the synthesizers
  logic src_level; // Selected source level
  logic div_clk; // Divider output
  logic [7:0] status_word;

  assign channel_four_source_select = ocfc_src_t'(output_four_control_q[OCFC_SRC_LSB +: 2]);
  assign fmt = ocfc_fmt_t'(output_four_control_q[OCFC_FMT_LSB +: 2]);
  assign channel_four_drive_mode_a = output_four_control_q[OCFC_MODE_A_LSB +: 2];
  assign channel_four_drive_mode_b = output_four_control_q[OCFC_MODE_B_LSB +: 2];

  // ****************************************************************
  // Write channels
  // ****************************************************************
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  // Address and data may come in either order; the write lands once both are held
  assign do_write = aw_full_q & w_full_q;
  assign aw_full_d = (aw_full_q & ~do_write) | aw_take;
  assign w_full_d = (w_full_q & ~do_write) | w_take;
  assign bvalid_d = (s_axi_bvalid & ~s_axi_bready) | do_write;

  // Handshake flags and ready outputs; ready is low while a response waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      s_axi_awready <= ~aw_full_d & ~bvalid_d;
      s_axi_wready <= ~w_full_d & ~bvalid_d;
      s_axi_bvalid <= bvalid_d;
    end
  end

  // Capture of address and data as each is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_idx_q <= 6'h00;
      aw_ok_q <= 1'b0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
        // Status is read-only but answers OKAY; writes there are dropped
        aw_ok_q <= (s_axi_awaddr[ADDR_W-1:2] == OCFC_IDX_CONTROL) ||
                   (s_axi_awaddr[ADDR_W-1:2] == OCFC_IDX_DIVIDER) ||
                   (s_axi_awaddr[ADDR_W-1:2] == OCFC_IDX_STATUS);
      end
      if (w_take) begin
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
    end
  end

  // Write response: unmapped addresses get SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= OCFC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= aw_ok_q ? OCFC_RESP_OKAY : OCFC_RESP_SLVERR;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Only byte lane 0 carries register bits; other lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_four_control_q <= OCFC_CONTROL_RST;
      output_four_divider_q <= OCFC_DIVIDER_RST;
    end else if (do_write && w_lane_q) begin
      if (aw_idx_q == OCFC_IDX_CONTROL) begin
        output_four_control_q <= w_byte_q;
      end
      if (aw_idx_q == OCFC_IDX_DIVIDER) begin
        output_four_divider_q <= w_byte_q;
      end
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];
  assign status_word = {3'h0, out_neg, out_pos, out_neg_oe, out_pos_oe, divider_active};

  // One read in flight; data is latched with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= OCFC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        // Upper 24 bits always read as zero
        case (ar_idx)
          OCFC_IDX_CONTROL: begin
            s_axi_rdata <= {24'h00_0000, output_four_control_q};
            s_axi_rresp <= OCFC_RESP_OKAY;
          end
          OCFC_IDX_DIVIDER: begin
            s_axi_rdata <= {24'h00_0000, output_four_divider_q};
            s_axi_rresp <= OCFC_RESP_OKAY;
          end
          OCFC_IDX_STATUS: begin
            s_axi_rdata <= {24'h00_0000, status_word};
            s_axi_rresp <= OCFC_RESP_OKAY;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= OCFC_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Source selection and divider
  // ****************************************************************
  always_comb begin
    case (channel_four_source_select)
      OCFC_SRC_SYNTH_FIRST: src_level = first_synthesizer_clk;
      OCFC_SRC_SYNTH_SECOND: src_level = second_synthesizer_clk;
      OCFC_SRC_REF_PRIMARY: src_level = primary_reference_clk;
      default: src_level = secondary_reference_clk;
    endcase
  end

  assign synth_src = (channel_four_source_select == OCFC_SRC_SYNTH_FIRST) ||
                     (channel_four_source_select == OCFC_SRC_SYNTH_SECOND);

  ocfc_divider #(
    .DIV_W(DIV_W)
  ) u_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_level(src_level),
    .ratio_code(output_four_divider_q),
    .bypass(~synth_src),
    .div_clk_q(div_clk)
  );

  // ****************************************************************
  // Output stage
  // ****************************************************************
  // Single-ended leg coding: {enable, level}
  function automatic logic [1:0] leg_drive(input logic [1:0] mode, input logic clk);
    case (ocfc_leg_t'(mode))
      OCFC_LEG_TRISTATE: leg_drive = 2'h0;
      OCFC_LEG_LOW: leg_drive = 2'h2;
      OCFC_LEG_INVERTED: leg_drive = {1'b1, ~clk};
      default: leg_drive = {1'b1, clk};
    endcase
  endfunction

  // Legs follow the divided clock; a format change takes effect next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_pos <= 1'b0;
      out_pos_oe <= 1'b0;
      out_neg <= 1'b0;
      out_neg_oe <= 1'b0;
    end else begin
      case (fmt)
        OCFC_FMT_OFF: begin
          // Mode fields are ignored while disabled
          out_pos <= 1'b0;
          out_pos_oe <= 1'b0;
          out_neg <= 1'b0;
          out_neg_oe <= 1'b0;
        end
        OCFC_FMT_CMOS: begin
          {out_pos_oe, out_pos} <= leg_drive(channel_four_drive_mode_a, div_clk);
          {out_neg_oe, out_neg} <= leg_drive(channel_four_drive_mode_b, div_clk);
        end
        default: begin
          // Differential pair, complementary legs
          out_pos <= div_clk;
          out_pos_oe <= 1'b1;
          out_neg <= ~div_clk;
          out_neg_oe <= 1'b1;
        end
      endcase
    end
  end

  // Analog settings presented to the driver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      driver_format <= OCFC_FMT_AC_DIFF;
      tail_current_ma <= OCFC_TAIL_NONE;
      hcsl_load_code <= OCFC_LOAD_TRISTATE;
      divider_active <= 1'b0;
    end else begin
      driver_format <= fmt;
      divider_active <= synth_src;
      hcsl_load_code <= (fmt == OCFC_FMT_HCSL) ? channel_four_drive_mode_b : OCFC_LOAD_TRISTATE;
      if (fmt == OCFC_FMT_AC_DIFF || fmt == OCFC_FMT_HCSL) begin
        case (channel_four_drive_mode_a)
          2'h0: tail_current_ma <= OCFC_TAIL_4MA;
          2'h1: tail_current_ma <= OCFC_TAIL_6MA;
          2'h2: tail_current_ma <= OCFC_TAIL_8MA;
          default: tail_current_ma <= (fmt == OCFC_FMT_HCSL) ? OCFC_TAIL_16MA : OCFC_TAIL_8MA;
        endcase
      end else begin
        tail_current_ma <= OCFC_TAIL_NONE;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_route_ref;
    (channel_four_source_select == OCFC_SRC_REF_PRIMARY && fmt == OCFC_FMT_AC_DIFF &&
     $past(output_four_control_q, 1) == output_four_control_q &&
     $past(output_four_control_q, 2) == output_four_control_q) |-> (out_pos == $past(primary_reference_clk, 2));
  endproperty
  a_route_ref: assert property (p_route_ref) else $error("primary reference not routed undivided");

  property p_off_idle;
    (fmt == OCFC_FMT_OFF) |=> (!out_pos_oe && !out_neg_oe && !out_pos && !out_neg);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("disabled driver still active");

  property p_hcsl_tail;
    (fmt == OCFC_FMT_HCSL && channel_four_drive_mode_a == 2'h3) |=> (tail_current_ma == OCFC_TAIL_16MA);
  endproperty
  a_hcsl_tail: assert property (p_hcsl_tail) else $error("HCSL top tail current wrong");

  property p_cmos_low;
    (fmt == OCFC_FMT_CMOS && channel_four_drive_mode_a == 2'h1) |=> (out_pos_oe && !out_pos);
  endproperty
  a_cmos_low: assert property (p_cmos_low) else $error("positive leg not driven low");

  property p_hcsl_load;
    (fmt == OCFC_FMT_HCSL) |=> (hcsl_load_code == $past(channel_four_drive_mode_b) && driver_format == OCFC_FMT_HCSL);
  endproperty
  a_hcsl_load: assert property (p_hcsl_load) else $error("HCSL load code not applied");

  property p_reset_values;
    $rose(aresetn) |-> (output_four_divider_q == OCFC_DIVIDER_RST && output_four_control_q == OCFC_CONTROL_RST);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("register reset values wrong");

  property p_div_flag;
    (!synth_src) |=> !divider_active;
  endproperty
  a_div_flag: assert property (p_div_flag) else $error("divider shown active for reference");

  property p_bvalid_hold;
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");

  property p_read_answer;
    ar_take |=> (s_axi_rvalid && !s_axi_arready);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");

  c_write: cover property (do_write && w_lane_q && aw_idx_q == OCFC_IDX_CONTROL);
  c_cmos: cover property (fmt == OCFC_FMT_CMOS && out_pos_oe && out_neg_oe);
  c_divided: cover property (synth_src && output_four_divider_q != 8'h00 && $rose(out_pos));

endmodule // ocfc_channel

// ===== logic/ocfc_pkg.sv
// Package: register map, field layout, reset values and codes of the channel four clock control
package ocfc_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] OCFC_IDX_CONTROL = 6'h25; // Source, format and drive modes
  localparam logic [5:0] OCFC_IDX_DIVIDER = 6'h26; // Output divider code
  localparam logic [5:0] OCFC_IDX_STATUS = 6'h27; // Live state of the output stage

  // ****************************************************************
  // Field positions inside the control register
  // ****************************************************************
  localparam int OCFC_SRC_LSB = 6; // Source selector [7:6]
  localparam int OCFC_FMT_LSB = 4; // Driver format [5:4]
  localparam int OCFC_MODE_A_LSB = 2; // First mode field [3:2]
  localparam int OCFC_MODE_B_LSB = 0; // Second mode field [1:0]

  // ****************************************************************
  // Field positions inside the status register
  // ****************************************************************
  localparam int OCFC_ST_DIV_ACTIVE = 0; // Divider in the path
  localparam int OCFC_ST_POS_OE = 1; // Positive leg driven
  localparam int OCFC_ST_NEG_OE = 2; // Negative leg driven
  localparam int OCFC_ST_POS = 3; // Positive leg level
  localparam int OCFC_ST_NEG = 4; // Negative leg level

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] OCFC_CONTROL_RST = 8'h18; // Source 0, format 1, mode a 2, mode b 0
  localparam logic [7:0] OCFC_DIVIDER_RST = 8'h02; // Divide by three

  // ****************************************************************
  // Tail current figures in mA and bus response codes
  // ****************************************************************
  localparam logic [4:0] OCFC_TAIL_4MA = 5'h04;
  localparam logic [4:0] OCFC_TAIL_6MA = 5'h06;
  localparam logic [4:0] OCFC_TAIL_8MA = 5'h08;
  localparam logic [4:0] OCFC_TAIL_16MA = 5'h10;
  localparam logic [4:0] OCFC_TAIL_NONE = 5'h00;
  localparam logic [1:0] OCFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OCFC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] OCFC_LOAD_TRISTATE = 2'h0; // Load code when no HCSL load applies

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    OCFC_SRC_SYNTH_FIRST = 2'h0,
    OCFC_SRC_SYNTH_SECOND = 2'h1,
    OCFC_SRC_REF_PRIMARY = 2'h2,
    OCFC_SRC_REF_SECONDARY = 2'h3
  } ocfc_src_t;

  typedef enum logic [1:0] {
    OCFC_FMT_OFF = 2'h0,
    OCFC_FMT_AC_DIFF = 2'h1,
    OCFC_FMT_HCSL = 2'h2,
    OCFC_FMT_CMOS = 2'h3
  } ocfc_fmt_t;

  // Single-ended leg coding, shared by both mode fields
  typedef enum logic [1:0] {
    OCFC_LEG_TRISTATE = 2'h0,
    OCFC_LEG_LOW = 2'h1,
    OCFC_LEG_INVERTED = 2'h2,
    OCFC_LEG_TRUE = 2'h3
  } ocfc_leg_t;

endpackage

// ===== logic/ocfc_divider.sv
// Output divider for channel four: divide by code plus one, or pass the source through
module ocfc_divider #(
  parameter int DIV_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic src_level,
  input wire logic [DIV_W-1:0] ratio_code,
  input wire logic bypass,
  output logic div_clk_q
);
  import ocfc_pkg::*;

  logic src_prev_q; // Source level of the last cycle
  logic [DIV_W-1:0] cnt_q; // Source rising edges since wrap
  logic [DIV_W-1:0] cnt_d;
  logic [DIV_W-1:0] half; // Edge count at which the output drops
  logic src_rise;

  assign src_rise = src_level & ~src_prev_q;
  assign half = DIV_W'(({1'b0, ratio_code} + {{DIV_W{1'b0}}, 1'b1}) >> 1);
  // A code lowered below the count wraps at once instead of running round
  assign cnt_d = (cnt_q >= ratio_code) ? '0 : DIV_W'(cnt_q + 1'b1);

  // ****************************************************************
  // Edge detect
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  // ****************************************************************
  // Counter and output level
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      div_clk_q <= 1'b0;
    end else if (bypass || ratio_code == '0) begin
      // Reference source, or ratio 1: follow the source level
      cnt_q <= '0;
      div_clk_q <= src_level;
    end else if (src_rise) begin
      // Odd ratios give a short high phase; the period is exact
      cnt_q <= cnt_d;
      div_clk_q <= (cnt_d < half);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_div_wrap;
    @(posedge aclk) disable iff (!aresetn)
      (!bypass && ratio_code != '0 && src_rise && cnt_q >= ratio_code) |=> (cnt_q == '0);
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider count did not wrap at code");

endmodule // ocfc_divider

// ===== verification/output_channel_four_control_tb.sv
// Self-checking bench of the channel four clock output control block
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end

module output_channel_four_control_tb import ocfc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Signals
  // ****************************************************************
  typedef struct {logic [31:0] data; logic [1:0] resp;} ocfc_rexp_t; // Expected read answer
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, hcsl_load_code;
  logic first_synthesizer_clk, second_synthesizer_clk, primary_reference_clk, secondary_reference_clk;
  logic out_pos, out_pos_oe, out_neg, out_neg_oe, divider_active;
  ocfc_fmt_t driver_format;
  logic [4:0] tail_current_ma;
  int err_count = 0; // Mismatches
  int n_tests = 0; // Comparisons made
  int cyc = 0; // Free cycle count for the source clocks
  ocfc_rexp_t rq[$]; // Notes of expected read answers
  logic [1:0] bq[$]; // Notes of expected write responses
  ocfc_rexp_t re;
  logic [1:0] be;
  logic [7:0] rnd = 8'h5d; // Random state, fixed seed
  localparam logic [7:0] A_CTL = {OCFC_IDX_CONTROL, 2'h0};
  localparam logic [7:0] A_DIV = {OCFC_IDX_DIVIDER, 2'h0};
  localparam logic [7:0] A_ST = {OCFC_IDX_STATUS, 2'h0};

  ocfc_channel u_ocfc_channel (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .first_synthesizer_clk(first_synthesizer_clk), .second_synthesizer_clk(second_synthesizer_clk),
    .primary_reference_clk(primary_reference_clk), .secondary_reference_clk(secondary_reference_clk),
    .out_pos(out_pos), .out_pos_oe(out_pos_oe), .out_neg(out_neg), .out_neg_oe(out_neg_oe),
    .driver_format(driver_format), .tail_current_ma(tail_current_ma), .hcsl_load_code(hcsl_load_code),
    .divider_active(divider_active));

  // ****************************************************************
  // Clock and source levels
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Distinct source periods (8, 12, 20, 32 cycles) let the output rate name the chosen source
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    first_synthesizer_clk <= (cyc % 8) < 4;
    second_synthesizer_clk <= (cyc % 12) < 6;
    primary_reference_clk <= (cyc % 20) < 10;
    secondary_reference_clk <= (cyc % 32) < 16;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One write; address and data are released as each is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st, input logic [1:0] r);
    bit done;
    done = 0;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    if (!done) begin
      err_count++;
      complete_run();
    end
  endtask

  // One read; the monitor compares the answer with the note
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit done;
    done = 0;
    rq.push_back('{d, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid;
    end
    s_axi_rready <= 1'b0;
    if (!done) begin
      err_count++;
      complete_run();
    end
  endtask

  // Rising edges of the positive leg over 480 cycles, one edge of slack for phase
  task automatic count_edges(input int expn);
    int c;
    logic p;
    c = 0;
    p = out_pos;
    repeat (480) begin
      @(posedge aclk);
      if (out_pos && !p) c++;
      p = out_pos;
    end
    `CHK("edge count in range", 1'b1, (c >= expn - 1 && c <= expn + 1))
  endtask

  // ****************************************************************
  // Monitor: oldest note against each bus answer
  // ****************************************************************
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      `CHK("rdata", re.data, s_axi_rdata)
      `CHK("rresp", re.resp, s_axi_rresp)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      be = bq.pop_front();
      `CHK("bresp", be, s_axi_bresp)
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [1:0] f, a, b;
    logic [4:0] t;
    int exp_e[4];
    exp_e = '{30, 20, 24, 15};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset values of both registers and the stage they set up
    rd(A_CTL, 32'h18, OCFC_RESP_OKAY);
    rd(A_DIV, 32'h02, OCFC_RESP_OKAY);
    `CHK("format", OCFC_FMT_AC_DIFF, driver_format)
    `CHK("tail", OCFC_TAIL_8MA, tail_current_ma)
    `CHK("divider active", 1'b1, divider_active)
    // Every format with every first mode code, random second mode code
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      {f, a, b} = {i[3:0], rnd[1:0]};
      wr(A_CTL, {2'h2, f, a, b}, 4'h1, OCFC_RESP_OKAY);
      rd(A_CTL, {24'h0, 2'h2, f, a, b}, OCFC_RESP_OKAY);
      repeat (3) @(posedge aclk);
      t = (f == 2'h0 || f == 2'h3) ? 5'h00 : (a == 2'h0) ? 5'h04 : (a == 2'h1) ? 5'h06 : (a == 2'h2) ? 5'h08 :
        (f == 2'h2) ? 5'h10 : 5'h08;
      `CHK("format", ocfc_fmt_t'(f), driver_format)
      `CHK("tail", t, tail_current_ma)
      `CHK("load", (f == 2'h2) ? b : 2'h0, hcsl_load_code)
      if (f == 2'h0) `CHK("off legs", 4'h0, {out_pos, out_pos_oe, out_neg, out_neg_oe})
      if (f == 2'h1 || f == 2'h2) `CHK("diff legs", 3'h7, {out_pos ^ out_neg, out_pos_oe, out_neg_oe})
      if (f == 2'h3) begin
        `CHK("pos oe", a != 2'h0, out_pos_oe)
        `CHK("neg oe", b != 2'h0, out_neg_oe)
        if (a == 2'h1) `CHK("pos low", 1'b0, out_pos)
        if (a[1] && b[1]) `CHK("leg polarity", out_neg ^ (a != b), out_pos)
      end
    end
    // Each source at divide by two: references bypass the divider
    wr(A_DIV, 8'h01, 4'h1, OCFC_RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      wr(A_CTL, {s[1:0], 6'h18}, 4'h1, OCFC_RESP_OKAY);
      repeat (3) @(posedge aclk);
      `CHK("divider active", s < 2, divider_active)
      count_edges(exp_e[s]);
    end
    // Ratio codes on the first synthesizer: code 0 follows, code 3 divides by four
    wr(A_CTL, 8'h18, 4'h1, OCFC_RESP_OKAY);
    wr(A_DIV, 8'h00, 4'h1, OCFC_RESP_OKAY);
    count_edges(60);
    wr(A_DIV, 8'h03, 4'h1, OCFC_RESP_OKAY);
    count_edges(15);
    // Random and top codes read back whole
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      wr(A_DIV, (k == 2) ? 8'hff : rnd, 4'h1, OCFC_RESP_OKAY);
      rd(A_DIV, {24'h0, (k == 2) ? 8'hff : rnd}, OCFC_RESP_OKAY);
    end
    // Bus corner cases: unmapped place, masked lane, read-only status
    rd(8'h00, 32'h0, OCFC_RESP_SLVERR);
    wr(8'h00, 8'h55, 4'hf, OCFC_RESP_SLVERR);
    wr(A_CTL, 8'hbf, 4'h1, OCFC_RESP_OKAY);
    wr(A_CTL, 8'h00, 4'h0, OCFC_RESP_OKAY);
    rd(A_CTL, 32'hbf, OCFC_RESP_OKAY);
    // Reference source, both single-ended legs driven low: only the two enables show
    wr(A_CTL, 8'hb5, 4'h1, OCFC_RESP_OKAY);
    wr(A_ST, 8'hff, 4'h1, OCFC_RESP_OKAY);
    rd(A_ST, 32'h06, OCFC_RESP_OKAY);
    // Disabled driver on a reference source: the whole status reads zero
    wr(A_CTL, 8'h80, 4'h1, OCFC_RESP_OKAY);
    rd(A_ST, 32'h0, OCFC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    complete_run();
  end
endmodule // output_channel_four_control_tb
